// ===== mpe_defines.vh
// Constants for the motor PWM output and emergency stop block
`ifndef MPE_DEFINES_VH
`define MPE_DEFINES_VH
`define MPE_ADDR_OUTCTRL 8'h00
`define MPE_ADDR_MODE 8'h04
`define MPE_ADDR_TBMODE 8'h08
`define MPE_ADDR_STATUS 8'h0C
`define MPE_ADDR_KEY 8'h10
`define MPE_ADDR_EMGCTRL 8'h14
`define MPE_ADDR_U_PHASE_COMPARE 8'h18
`define MPE_ADDR_V_PHASE_COMPARE 8'h1C
`define MPE_ADDR_W_PHASE_COMPARE 8'h20
`define MPE_OUT_LVL_LSB 0
`define MPE_OUT_PWM_LSB 8
`define MPE_MODE_SYNC_BIT 4
`define MPE_MODE_POLH_BIT 3
`define MPE_MODE_POLL_BIT 2
`define MPE_STAT_ACTIVE_BIT 0
`define MPE_STAT_LEVEL_BIT 1
`define MPE_CTL_EN_BIT 0
`define MPE_CTL_REL_BIT 1
`define MPE_CTL_MODE_LSB 3
`define MPE_CTL_TBEN_BIT 5
`define MPE_CTL_CNT_LSB 8
`define MPE_CTL_RESET 12'h0_039
`define MPE_KEY_FIRST 8'h5A
`define MPE_KEY_SECOND 8'hA5
`define MPE_EMG_NONE 2'b00
`define MPE_EMG_UPPER_ON 2'b01
`define MPE_EMG_LOWER_ON 2'b10
`define MPE_EMG_ALL_OFF 2'b11
`define MPE_RESP_OKAY 2'b00
`define MPE_RESP_SLVERR 2'b10
`endif

// ===== mpe_pwm_emg.v
// Six-line motor output mapping with emergency stop, AXI4-Lite registers
`include "mpe_defines.vh"

// Functional notes
// - Active low: level code sets fixed levels
// - Active high PWM mode: code selects PWM/low
// - Protection activates while emergency input low
// - Falling input disables outputs per stop mode, raises interrupt
// - Stop mode can float the output ports
// - Tool break disables outputs per port mode
// - Tool break can float the output ports
// - Status bit reads one while protection active
// - Release ignored while emergency input low
// - Enable clears only after correct key pair
// - Protection enabled and active after reset
// - Select bit picks fixed level or PWM
// - Stop mode chooses on/off and float pattern
// - Polarity bits per upper and lower group
module mpe_pwm_emg #(
  parameter PHASES = 3,
  parameter CMP_WIDTH = 16
) (
  input wire clock,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [PHASES-1:0] phasePwm,
  input wire emergencyPin,
  input wire portFunctionSelect,
  input wire toolBreak,
  output reg [PHASES-1:0] upperOut,
  output reg [PHASES-1:0] lowerOut,
  output reg [PHASES-1:0] upperOe,
  output reg [PHASES-1:0] lowerOe,
  output reg emergencyInterrupt
);

  localparam KEY_IDLE = 2'd0;
  localparam KEY_FIRST = 2'd1;
  localparam KEY_ARMED = 2'd2;
  localparam [11:0] CTL_RESET = `MPE_CTL_RESET;

  reg [2*PHASES-1:0] levelCode;
  reg [PHASES-1:0] pwmSelect;
  reg polarityHigh;
  reg polarityLow;
  reg syncTimingMode;
  reg [1:0] toolBreakPortMode;
  reg emergencyEnable;
  reg [1:0] emergencyStopMode;
  reg toolBreakEnable;
  reg [3:0] filterCount;
  reg [CMP_WIDTH-1:0] compareReg [0:2];
  reg emergencyActive;
  reg [1:0] keyState;
  reg [2:0] pinSync;
  reg inputLevel;
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;

  wire doWrite;
  wire [31:0] byteMask;
  wire [31:0] writeWord;
  wire levelRaw;
  wire inputFall;
  wire breakActive;
  reg [31:0] oldWord;
  reg addrHit;
  reg [31:0] readWord;
  reg readHit;
  reg [1:0] next_keyState;
  wire [PHASES-1:0] next_upper;
  wire [PHASES-1:0] next_lower;
  wire [PHASES-1:0] next_upperOe;
  wire [PHASES-1:0] next_lowerOe;
  integer i;

  // Register read-back, shared by the read channel and byte merging
  function [32:0] regRead;
    input [7:0] addr;
    begin
      regRead = 33'h0_0000_0000;
      case (addr)
        `MPE_ADDR_OUTCTRL: regRead = {1'b1, 21'd0, pwmSelect, 2'd0, levelCode};
        `MPE_ADDR_MODE: regRead = {1'b1, 27'd0, syncTimingMode, polarityHigh,
                                   polarityLow, 2'd0};
        `MPE_ADDR_TBMODE: regRead = {1'b1, 30'd0, toolBreakPortMode};
        `MPE_ADDR_STATUS: regRead = {1'b1, 30'd0, inputLevel, emergencyActive};
        `MPE_ADDR_KEY: regRead = {1'b1, 32'd0};
        `MPE_ADDR_EMGCTRL: regRead = {1'b1, 20'd0, filterCount, 2'd0, toolBreakEnable,
                                      emergencyStopMode, 2'd0, emergencyEnable};
        `MPE_ADDR_U_PHASE_COMPARE: regRead = {1'b1, {(32-CMP_WIDTH){1'b0}}, compareReg[0]};
        `MPE_ADDR_V_PHASE_COMPARE: regRead = {1'b1, {(32-CMP_WIDTH){1'b0}}, compareReg[1]};
        `MPE_ADDR_W_PHASE_COMPARE: regRead = {1'b1, {(32-CMP_WIDTH){1'b0}}, compareReg[2]};
        default: regRead = 33'h0_0000_0000;
      endcase
    end
  endfunction

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  assign writeWord = (oldWord & ~byteMask) | (wData & byteMask);

  always @* begin
    {addrHit, oldWord} = regRead(awAddr);
    {readHit, readWord} = regRead(s_axi_araddr);
  end

  // Write address and data may arrive in either order
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MPE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addrHit ? `MPE_RESP_OKAY : `MPE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MPE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= readHit ? `MPE_RESP_OKAY : `MPE_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin passes three flops; a level counts once the last two agree
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinSync <= 3'b000;
      inputLevel <= 1'b0;
    end else begin
      pinSync <= {pinSync[1:0], emergencyPin};
      if (pinSync[1] == pinSync[2]) begin
        inputLevel <= pinSync[2] & portFunctionSelect;
      end
    end
  end

  // Pin left as a plain port reads low, so protection holds after reset
  assign levelRaw = inputLevel;
  assign inputFall = (pinSync[1] == pinSync[2]) && inputLevel
                     && !(pinSync[2] & portFunctionSelect);
  assign breakActive = toolBreak && toolBreakEnable;

  // Key sequence guarding the enable bit
  always @* begin
    next_keyState = keyState;
    if (doWrite) begin
      if (awAddr == `MPE_ADDR_KEY && wStrb[0]) begin
        if (keyState == KEY_IDLE && wData[7:0] == `MPE_KEY_FIRST) begin
          next_keyState = KEY_FIRST;
        end else if (keyState == KEY_FIRST && wData[7:0] == `MPE_KEY_SECOND) begin
          next_keyState = KEY_ARMED;
        end else begin
          next_keyState = KEY_IDLE;
        end
      end else begin
        next_keyState = KEY_IDLE;
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      levelCode <= {2*PHASES{1'b0}};
      pwmSelect <= {PHASES{1'b0}};
      polarityHigh <= 1'b0;
      polarityLow <= 1'b0;
      syncTimingMode <= 1'b0;
      toolBreakPortMode <= 2'b00;
      emergencyEnable <= CTL_RESET[`MPE_CTL_EN_BIT];
      emergencyStopMode <= CTL_RESET[`MPE_CTL_MODE_LSB +: 2];
      toolBreakEnable <= CTL_RESET[`MPE_CTL_TBEN_BIT];
      filterCount <= CTL_RESET[`MPE_CTL_CNT_LSB +: 4];
      for (i = 0; i < 3; i = i + 1) begin
        compareReg[i] <= {CMP_WIDTH{1'b0}};
      end
      keyState <= KEY_IDLE;
    end else begin
      keyState <= next_keyState;
      if (doWrite) begin
        case (awAddr)
          `MPE_ADDR_OUTCTRL: begin
            levelCode <= writeWord[`MPE_OUT_LVL_LSB +: 2*PHASES];
            pwmSelect <= writeWord[`MPE_OUT_PWM_LSB +: PHASES];
          end
          `MPE_ADDR_MODE: begin
            syncTimingMode <= writeWord[`MPE_MODE_SYNC_BIT];
            polarityHigh <= writeWord[`MPE_MODE_POLH_BIT];
            polarityLow <= writeWord[`MPE_MODE_POLL_BIT];
          end
          `MPE_ADDR_TBMODE: toolBreakPortMode <= writeWord[1:0];
          `MPE_ADDR_EMGCTRL: begin
            // Clearing the enable needs the armed key pair
            if (writeWord[`MPE_CTL_EN_BIT] || keyState == KEY_ARMED) begin
              emergencyEnable <= writeWord[`MPE_CTL_EN_BIT];
            end
            emergencyStopMode <= writeWord[`MPE_CTL_MODE_LSB +: 2];
            toolBreakEnable <= writeWord[`MPE_CTL_TBEN_BIT];
            filterCount <= writeWord[`MPE_CTL_CNT_LSB +: 4];
          end
          `MPE_ADDR_U_PHASE_COMPARE: compareReg[0] <= writeWord[CMP_WIDTH-1:0];
          `MPE_ADDR_V_PHASE_COMPARE: compareReg[1] <= writeWord[CMP_WIDTH-1:0];
          `MPE_ADDR_W_PHASE_COMPARE: compareReg[2] <= writeWord[CMP_WIDTH-1:0];
          default: keyState <= next_keyState;
        endcase
      end
    end
  end

  // Protection state; a low input beats any release in the same cycle
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      emergencyActive <= 1'b1;
      emergencyInterrupt <= 1'b0;
    end else begin
      emergencyInterrupt <= inputFall && emergencyEnable;
      if (!emergencyEnable) begin
        emergencyActive <= 1'b0;
      end else if (!levelRaw || inputFall) begin
        // Set with the interrupt so the pins react on the very next edge
        emergencyActive <= 1'b1;
      end else if (doWrite && awAddr == `MPE_ADDR_EMGCTRL
                   && writeWord[`MPE_CTL_REL_BIT]) begin
        emergencyActive <= 1'b0;
      end
    end
  end

  // Per-phase mapping of level codes, select bits and polarity
  genvar g;
  generate
    for (g = 0; g < PHASES; g = g + 1) begin : gPhase
      wire [1:0] code = levelCode[2*g +: 2];
      wire upperOn = pwmSelect[g] ? (phasePwm[g] && code != 2'b01)
                                  : code[1];
      wire lowerOn = pwmSelect[g] ? (!phasePwm[g] && code != 2'b10)
                                  : code[0];
      reg upOn;
      reg loOn;
      reg upZ;
      reg loZ;
      always @* begin
        upOn = upperOn;
        loOn = lowerOn;
        upZ = 1'b0;
        loZ = 1'b0;
        if (emergencyActive) begin
          case (emergencyStopMode)
            `MPE_EMG_NONE: begin
              upZ = 1'b1;
              loZ = 1'b1;
            end
            `MPE_EMG_UPPER_ON: begin
              loOn = 1'b0;
              loZ = 1'b1;
            end
            `MPE_EMG_LOWER_ON: begin
              upOn = 1'b0;
              upZ = 1'b1;
            end
            default: begin
              upOn = 1'b0;
              loOn = 1'b0;
              upZ = 1'b1;
              loZ = 1'b1;
            end
          endcase
        end
        if (breakActive) begin
          if (toolBreakPortMode[0]) begin
            upOn = 1'b0;
            loOn = 1'b0;
          end
          if (toolBreakPortMode[1]) begin
            upZ = 1'b1;
            loZ = 1'b1;
          end
        end
      end
      assign next_upper[g] = polarityHigh ? upOn : !upOn;
      assign next_lower[g] = polarityLow ? loOn : !loOn;
      assign next_upperOe[g] = !upZ;
      assign next_lowerOe[g] = !loZ;
    end
  endgenerate

  // Registered pins; reset shows the active-low idle level with ports floated
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upperOut <= {PHASES{1'b1}};
      lowerOut <= {PHASES{1'b1}};
      upperOe <= {PHASES{1'b0}};
      lowerOe <= {PHASES{1'b0}};
    end else begin
      upperOut <= next_upper;
      lowerOut <= next_lower;
      upperOe <= next_upperOe;
      lowerOe <= next_lowerOe;
    end
  end

endmodule // mpe_pwm_emg

// ===== mpe_pwm_emg_chk.sv
// Port-level assertions for the motor output and emergency stop block
module mpe_pwm_emg_chk #(
  parameter PHASES = 3
) (
  input wire clock,
  input wire rst_b,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire emergencyPin,
  input wire portFunctionSelect,
  input wire [PHASES-1:0] upperOe,
  input wire [PHASES-1:0] lowerOe,
  input wire emergencyInterrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_irq_single: assert property (
    emergencyInterrupt |=> !emergencyInterrupt [*4]) else $error("interrupt not a pulse");
  a_irq_cause: assert property (
    emergencyInterrupt |-> !emergencyPin || !portFunctionSelect) else $error("stray interrupt");
  // Every stop mode floats at least one group, so this holds for all four
  a_emg_floats: assert property (
    emergencyInterrupt |=> (upperOe == '0) || (lowerOe == '0)) else $error("pins not floated");
  c_irq: cover property (emergencyInterrupt);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_floated: cover property (upperOe == '0 && lowerOe == '0);
endmodule // mpe_pwm_emg_chk

// ===== mpe_gate_model.sv
// Gate driver pads and emergency pin seen from the block's far side
module mpe_gate_model (
  input wire logic clock,
  input wire logic emgReq,
  input wire logic [2:0] pwmReq,
  input wire logic [2:0] upperOut,
  input wire logic [2:0] lowerOut,
  input wire logic [2:0] upperOe,
  input wire logic [2:0] lowerOe,
  output logic emergencyPin,
  output logic [2:0] phasePwm,
  output logic [2:0] upperPad,
  output logic [2:0] lowerPad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] flt = 3'h5;
  // Floated pads wander so a stale level never passes for a driven one
  always @(posedge clock) flt <= ~flt;
  // Pin pulled high, the fault source pulls it low
  assign emergencyPin = !emgReq;
  assign phasePwm = pwmReq;
  assign upperPad = (upperOe & upperOut) | (~upperOe & flt);
  assign lowerPad = (lowerOe & lowerOut) | (~lowerOe & ~flt);
endmodule // mpe_gate_model

// ===== tb.sv
// Register-level testbench for the motor output and emergency stop block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, pwmReq = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0, irqCount = '0, n_tests = '0, miscompares = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, emgReq = 0, portFunctionSelect = 0, toolBreak = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire emergencyPin, emergencyInterrupt;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] phasePwm, upperOut, lowerOut, upperOe, lowerOe, upperPad, lowerPad;
  logic [31:0] n, ctl;
  mpe_pwm_emg dut_u (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .phasePwm(phasePwm), .emergencyPin(emergencyPin),
    .portFunctionSelect(portFunctionSelect), .toolBreak(toolBreak),
    .upperOut(upperOut), .lowerOut(lowerOut), .upperOe(upperOe), .lowerOe(lowerOe),
    .emergencyInterrupt(emergencyInterrupt)
  );
  mpe_gate_model gate_u (
    .clock(clock), .emgReq(emgReq), .pwmReq(pwmReq),
    .upperOut(upperOut), .lowerOut(lowerOut), .upperOe(upperOe), .lowerOe(lowerOe),
    .emergencyPin(emergencyPin), .phasePwm(phasePwm),
    .upperPad(upperPad), .lowerPad(lowerPad)
  );
  initial begin
    forever #20ns clock = ~clock;
  end
  always @(posedge clock) if (emergencyInterrupt === 1'b1) irqCount <= irqCount + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitn(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  // Handshakes are sampled mid-cycle, where they equal the next edge's view
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    logic ar, ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid && s_axi_arready;
      ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (ok !== 1'b1);
    s_axi_rready <= 1'b0;
    check(32'(r), 32'(er));
    if (er == 2'h0) check(d, exp);
  endtask
  function automatic logic [5:0] mapx(input logic [1:0] c, input logic p, input logic [1:0] pol);
    logic [2:0] u, l;
    u = p ? (c == 2'h1 ? 3'h0 : 3'h5) : {3{c[1]}};
    l = p ? (c == 2'h2 ? 3'h0 : 3'h2) : {3{c[0]}};
    return {pol[1] ? u : ~u, pol[0] ? l : ~l};
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h14, 32'h0000_0039);
    rd(8'h0C, 32'h0000_0001);
    portFunctionSelect <= 1'b1;
    waitn(8);
    rd(8'h0C, 32'h0000_0003);
    wr(8'h00, 32'h0000_0000);
    wr(8'h14, 32'h0000_003B);
    rd(8'h0C, 32'h0000_0002);
    $display("startup test done");
    pwmReq <= 3'h5;
    for (int pol = 0; pol < 8; pol++) begin
      for (int k = 0; k < 8; k++) begin
        wr(8'h04, 32'(pol) << 2);
        wr(8'h00, {21'h0, {3{k[2]}}, 2'h0, {3{k[1:0]}}});
        waitn(2);
        check(32'({upperPad, lowerPad}), 32'(mapx(k[1:0], k[2], pol[1:0])));
        check(32'({upperOe, lowerOe}), 32'h0000_003F);
      end
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h18 + 8'(4 * i), 32'h0000_0400 - 32'(i));
      rd(8'h18 + 8'(4 * i), 32'h0000_0400 - 32'(i));
    end
    // U centre-off: code 00 must map like code 11 with active-high PWM
    wr(8'h00, 32'h0000_073C);
    waitn(2);
    check(32'({upperPad, lowerPad}), 32'(mapx(2'h0, 1'b1, 2'h3)));
    $display("mapping test done");
    wr(8'h00, 32'h0000_003F);
    wr(8'h08, 32'h0000_0003);
    toolBreak <= 1'b1;
    waitn(3);
    check(32'({upperOut, lowerOut, upperOe, lowerOe}), 32'h0000_0000);
    @(posedge clock);
    toolBreak <= 1'b0;
    waitn(3);
    check(32'({upperOe, lowerOe}), 32'h0000_003F);
    $display("tool break test done");
    for (int m = 0; m < 4; m++) begin
      ctl = 32'h0000_0021 | (32'(m) << 3);
      wr(8'h14, ctl);
      n = irqCount;
      emgReq <= 1'b1;
      waitn(10);
      check(irqCount, n + 1);
      check(32'({upperOut, upperOe, lowerOut, lowerOe}), 32'({m[1] ? 3'h0 : 3'h7,
        m == 1 ? 3'h7 : 3'h0, m[0] ? 3'h0 : 3'h7, m == 2 ? 3'h7 : 3'h0}));
      rd(8'h0C, 32'h0000_0001);
      wr(8'h14, ctl | 32'h0000_0002);
      rd(8'h0C, 32'h0000_0001);
      emgReq <= 1'b0;
      waitn(8);
      wr(8'h00, 32'h0000_0000);
      wr(8'h14, ctl | 32'h0000_0002);
      rd(8'h0C, 32'h0000_0002);
      wr(8'h00, 32'h0000_003F);
    end
    $display("emergency test done");
    // Wrong key, then an intervening write: both must leave protection on
    wr(8'h10, 32'h0000_005A);
    wr(8'h10, 32'h0000_0033);
    wr(8'h14, 32'h0000_0038);
    rd(8'h14, 32'h0000_0039);
    wr(8'h10, 32'h0000_005A);
    wr(8'h00, 32'h0000_003F);
    wr(8'h10, 32'h0000_00A5);
    wr(8'h14, 32'h0000_0038);
    rd(8'h14, 32'h0000_0039);
    wr(8'h10, 32'h0000_005A);
    wr(8'h10, 32'h0000_00A5);
    wr(8'h14, 32'h0000_0038);
    rd(8'h14, 32'h0000_0038);
    rd(8'h10, 32'h0000_0000);
    n = irqCount;
    emgReq <= 1'b1;
    waitn(10);
    check(irqCount, n);
    rd(8'h0C, 32'h0000_0000);
    emgReq <= 1'b0;
    wr(8'h40, 32'h0000_0000, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h2);
    $display("key and unmapped test done");
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
endmodule // tb
bind mpe_pwm_emg mpe_pwm_emg_chk #(.PHASES(PHASES)) chk_u (
  .clock(clock), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .emergencyPin(emergencyPin), .portFunctionSelect(portFunctionSelect),
  .upperOe(upperOe), .lowerOe(lowerOe), .emergencyInterrupt(emergencyInterrupt)
);
